// ### shared/tptc_pkg.sv
`default_nettype none
package tptc_pkg;
    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int CLK_MHZ = 250;
    // least power-on wait is used, so the reset comes as early as allowed
    localparam int T_POR_MS = 100;
    localparam int T_MAG_US = 4500;
    localparam int T_VD_SHORT_US = 400;
    localparam int T_VD_LONG_US = 1200;
    localparam int T_XFER_US = 100;
    localparam int US_PER_MS = 1000;
    // ****************************************************************
    // sizes
    // ****************************************************************
    localparam int CODE_W = 8;
    localparam int CNT_W = 25;
    localparam int ADR_W = 8;
    localparam int DAT_W = 32;
    // ****************************************************************
    // register map
    // ****************************************************************
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_STAT = 8'h04;
    localparam logic [31:0] CTRL_RESET = 32'h0;
    localparam int CTRL_INHIBIT = 0;
    localparam int STAT_CODE_LSB = 0;
    localparam int STAT_PRIME = 8;
    localparam int STAT_VD_BUSY = 9;
    localparam int STAT_XFER_BUSY = 10;
    localparam int STAT_FEED = 11;
    localparam int STAT_POR_DONE = 12;
    localparam int STAT_BUF_FULL = 13;
    // ****************************************************************
    // types
    // ****************************************************************
    typedef enum {TPTC_VD_IDLE, TPTC_VD_TIMED} tptc_vd_state_t;
endpackage
`default_nettype wire

// ### logic/tptc_one_shot.sv
`timescale 1ns/1ps
`default_nettype none
module tptc_one_shot #(
    parameter int CNT_W = 25
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic start,
    input wire logic [CNT_W-1:0] len,
    output logic busy,
    output logic done
);
    logic [CNT_W-1:0] cnt;
    wire last = busy && (cnt == '0);

    // busy for exactly len cycles; a new start retriggers
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cnt <= '0;
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= last && !start;
            if (start) begin
                cnt <= len - 1'b1;
                busy <= 1'b1;
            end else if (last) begin
                busy <= 1'b0;
            end else if (busy) begin
                cnt <= cnt - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ### logic/tptc_buf.sv
`timescale 1ns/1ps
`default_nettype none
module tptc_buf #(
    parameter int W = 8,
    parameter int DEPTH = 2
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);
    localparam logic [PW:0] FULL_CNT = (PW+1)'(DEPTH);
    localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

    logic [W-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [PW:0] count;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    wire [PW:0] next_count = count + (PW+1)'(push) - (PW+1)'(pop);

    assign out_data = mem[rd_ptr];

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            in_ready <= 1'b1;
            out_valid <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == LAST_PTR) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == LAST_PTR) ? '0 : rd_ptr + 1'b1;
            end
            count <= next_count;
            in_ready <= next_count != FULL_CNT;
            out_valid <= next_count != '0;
        end
    end
endmodule
`default_nettype wire

// ### logic/tptc_top.sv
// Notes on behaviour
// - after power-up wait, one distributor reset pulse
// - shift pulse copies signal register into storage
// - armed code magnets fire about 4.5 ms
// - delayed set pulse sets transfer-prime flag
// - prime flag arms one-shot, shortens variable delay
// - punch pickup pulse becomes rising trigger
// - variable delay 0.4 to 1.2 ms, edge triggers
// - prime clear means long, set means short
// - one-shot leading edge clears prime flag
// - one-shot trailing edge 100 us later transfers
// - transfer passes inhibit gate to all drivers
// - feed magnet fires on every transfer
// - line signal conditioned, forwarded to distributor
// - variable delay idle, timed, back to idle
// - unprimed time-out punches nothing, character kept
// - punching ends within the next character interval
`timescale 1ns/1ps
`default_nettype none
module tptc_top #(
    parameter int CODE_W = tptc_pkg::CODE_W,
    parameter int CNT_W = tptc_pkg::CNT_W,
    parameter int POR_CYC =
        tptc_pkg::T_POR_MS * tptc_pkg::US_PER_MS * tptc_pkg::CLK_MHZ,
    parameter int MAG_CYC = tptc_pkg::T_MAG_US * tptc_pkg::CLK_MHZ,
    parameter int VD_SHORT_CYC = tptc_pkg::T_VD_SHORT_US * tptc_pkg::CLK_MHZ,
    parameter int VD_LONG_CYC = tptc_pkg::T_VD_LONG_US * tptc_pkg::CLK_MHZ,
    parameter int XFER_CYC = tptc_pkg::T_XFER_US * tptc_pkg::CLK_MHZ,
    parameter int BUF_DEPTH = 2
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [tptc_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [tptc_pkg::DAT_W-1:0] wb_dat_i,
    output logic [tptc_pkg::DAT_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic line_in,
    output logic dist_serial,
    output logic dist_reset,
    input wire logic shift_pulse,
    input wire logic [CODE_W-1:0] signal_reg,
    input wire logic set_pulse,
    input wire logic pickup,
    output logic [CODE_W-1:0] code_magnet,
    output logic feed_magnet,
    output logic punched_valid,
    input wire logic punched_ready,
    output logic [CODE_W-1:0] punched_code
);
    // ****************************************************************
    // register bus
    // ****************************************************************
    logic [tptc_pkg::DAT_W-1:0] ctrl;
    logic [tptc_pkg::DAT_W-1:0] stat;
    logic [CODE_W-1:0] storage;
    logic transfer_prime_flag;
    logic vd_busy;
    logic xfer_busy;
    logic por_done;
    logic buf_ready;
    wire bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire hit_ctrl = wb_adr_i == tptc_pkg::ADR_CTRL;
    wire hit_stat = wb_adr_i == tptc_pkg::ADR_STAT;
    wire ctrl_wr = bus_req && wb_we_i && hit_ctrl && wb_sel_i[0];
    wire [tptc_pkg::DAT_W-1:0] rd_data = hit_ctrl ? ctrl :
                                          hit_stat ? stat : '0;

    always_comb begin
        stat = '0;
        stat[tptc_pkg::STAT_CODE_LSB +: CODE_W] = storage;
        stat[tptc_pkg::STAT_PRIME] = transfer_prime_flag;
        stat[tptc_pkg::STAT_VD_BUSY] = vd_busy;
        stat[tptc_pkg::STAT_XFER_BUSY] = xfer_busy;
        stat[tptc_pkg::STAT_FEED] = feed_magnet;
        stat[tptc_pkg::STAT_POR_DONE] = por_done;
        stat[tptc_pkg::STAT_BUF_FULL] = !buf_ready;
    end

    // unmapped addresses still ack, reading zero, so masters never hang
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
            ctrl <= tptc_pkg::CTRL_RESET;
        end else begin
            wb_ack_o <= bus_req;
            wb_dat_o <= bus_req ? rd_data : '0;
            if (ctrl_wr) begin
                ctrl[tptc_pkg::CTRL_INHIBIT] <=
                    wb_dat_i[tptc_pkg::CTRL_INHIBIT];
            end
        end
    end

    // ****************************************************************
    // power-on delay shaper and line input conditioner
    // ****************************************************************
    logic por_started;
    logic por_end;

    tptc_one_shot #(.CNT_W(CNT_W)) power_on_delay_shaper (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .start(!por_started),
        .len(CNT_W'(POR_CYC)),
        .busy(),
        .done(por_end)
    );

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            por_started <= 1'b0;
            por_done <= 1'b0;
            dist_reset <= 1'b0;
            dist_serial <= 1'b0;
        end else begin
            por_started <= 1'b1;
            dist_reset <= por_end && !por_done;
            por_done <= por_done || por_end;
            dist_serial <= line_in;
        end
    end

    // ****************************************************************
    // storage register and transfer prime flag
    // ****************************************************************
    logic vd_timeout;
    wire fire = vd_timeout && transfer_prime_flag;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            storage <= '0;
            transfer_prime_flag <= 1'b0;
        end else begin
            if (shift_pulse) begin
                storage <= signal_reg;
            end
            // set beats a clear that lands in the same cycle
            if (set_pulse) begin
                transfer_prime_flag <= 1'b1;
            end else if (fire) begin
                transfer_prime_flag <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // variable delay timer
    // ****************************************************************
    tptc_pkg::tptc_vd_state_t vd_state;
    tptc_pkg::tptc_vd_state_t next_vd_state;
    logic [CNT_W-1:0] vd_cnt;
    logic pickup_q;
    wire vd_trig = pickup && !pickup_q;
    wire vd_timed = vd_state == tptc_pkg::TPTC_VD_TIMED;
    // bias is re-read every cycle, so a prime arriving mid-way shortens
    // the running time-out as the analog circuit did
    wire short_hit = vd_cnt >= CNT_W'(VD_SHORT_CYC - 1);
    wire long_hit = vd_cnt >= CNT_W'(VD_LONG_CYC - 1);
    assign vd_timeout = vd_timed &&
        ((transfer_prime_flag && short_hit) || long_hit);
    assign vd_busy = vd_timed;

    always_comb begin
        next_vd_state = vd_state;
        case (vd_state)
            tptc_pkg::TPTC_VD_IDLE: begin
                if (vd_trig) begin
                    next_vd_state = tptc_pkg::TPTC_VD_TIMED;
                end
            end
            tptc_pkg::TPTC_VD_TIMED: begin
                if (vd_timeout) begin
                    next_vd_state = tptc_pkg::TPTC_VD_IDLE;
                end
            end
            default: begin
                next_vd_state = tptc_pkg::TPTC_VD_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            vd_state <= tptc_pkg::TPTC_VD_IDLE;
            vd_cnt <= '0;
            pickup_q <= 1'b0;
        end else begin
            pickup_q <= pickup;
            vd_state <= next_vd_state;
            vd_cnt <= vd_timed ? vd_cnt + 1'b1 : '0;
        end
    end

    // ****************************************************************
    // transfer one-shot, inhibit gate, magnet drivers
    // ****************************************************************
    logic xfer_end;
    logic mag_end;
    // a full echo buffer cancels the transfer, so the character is not punched and no word enters the buffer
    wire inhibit = ctrl[tptc_pkg::CTRL_INHIBIT] || !buf_ready;
    wire transfer = xfer_end && !inhibit;

    tptc_one_shot #(.CNT_W(CNT_W)) transfer_one_shot (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .start(fire),
        .len(CNT_W'(XFER_CYC)),
        .busy(xfer_busy),
        .done(xfer_end)
    );

    // magnet window 4.5 ms stays well inside one character interval
    tptc_one_shot #(.CNT_W(CNT_W)) magnet_timer (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .start(transfer),
        .len(CNT_W'(MAG_CYC)),
        .busy(),
        .done(mag_end)
    );

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            code_magnet <= '0;
            feed_magnet <= 1'b0;
        end else if (transfer) begin
            code_magnet <= storage;
            feed_magnet <= 1'b1;
        end else if (mag_end) begin
            code_magnet <= '0;
            feed_magnet <= 1'b0;
        end
    end

    tptc_buf #(.W(CODE_W), .DEPTH(BUF_DEPTH)) punched_buf (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .in_valid(transfer),
        .in_ready(buf_ready),
        .in_data(storage),
        .out_valid(punched_valid),
        .out_ready(punched_ready),
        .out_data(punched_code)
    );

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    a_store_copy: assert property (
        shift_pulse |=> storage == $past(signal_reg))
        else $error("storage did not copy signal register");
    a_store_hold: assert property (
        !shift_pulse |=> $stable(storage))
        else $error("storage changed without shift");
    a_prime_set: assert property (
        set_pulse |=> transfer_prime_flag)
        else $error("set pulse did not set prime");
    a_fire_clears: assert property (
        fire && !set_pulse |=> !transfer_prime_flag)
        else $error("fire did not clear prime");
    a_unprimed_quiet: assert property (
        vd_timeout && !transfer_prime_flag |=> !xfer_busy)
        else $error("unprimed time-out started transfer");
    a_vd_long: assert property (
        vd_timeout && !transfer_prime_flag |->
        vd_cnt == CNT_W'(VD_LONG_CYC - 1))
        else $error("long time-out length wrong");
    a_vd_enter: assert property (
        !vd_timed && vd_trig |=> vd_timed ##1 vd_cnt == CNT_W'(1))
        else $error("trigger did not start delay");
    a_xfer_delay: assert property (
        fire |=> xfer_busy [*3])
        else $error("transfer one-shot ended early");
    a_magnet_load: assert property (
        transfer |=> feed_magnet && code_magnet == $past(storage))
        else $error("magnets not driven on transfer");
    a_gate_inhibit: assert property (
        xfer_end && inhibit |=> $stable(feed_magnet) || !feed_magnet)
        else $error("inhibited transfer reached magnets");
    a_line_fwd: assert property (
        ##1 dist_serial == $past(line_in))
        else $error("line not forwarded");
    a_reset_once: assert property (
        dist_reset |=> !dist_reset && por_done)
        else $error("distributor reset not single");

    c_fire: cover property (fire);
    c_unprimed: cover property (vd_timeout && !transfer_prime_flag);
    c_transfer: cover property (transfer ##1 feed_magnet);
    c_buf_full: cover property (!buf_ready && xfer_end);
endmodule
`default_nettype wire

// ### test/tptc_far_model.sv
`timescale 1ns/1ps
`default_nettype none
module tptc_far_model #(
    parameter int SET_GAP = 5
) (
    input wire logic clk_sys,
    output logic shift_pulse,
    output logic [tptc_pkg::CODE_W-1:0] signal_reg,
    output logic set_pulse,
    output logic pickup
);
    initial begin
        shift_pulse = 1'b0;
        signal_reg = 8'hff;
        set_pulse = 1'b0;
        pickup = 1'b0;
    end
    // ****************************************************************
    // distributor: one character, shift then delayed set
    // ****************************************************************
    task automatic load_char(input logic [tptc_pkg::CODE_W-1:0] code);
        @(posedge clk_sys);
        signal_reg <= code;
        shift_pulse <= 1'b1;
        @(posedge clk_sys);
        shift_pulse <= 1'b0;
        repeat (SET_GAP) @(posedge clk_sys);
        set_pulse <= 1'b1;
        // set pulse also returns the signal register to all marks
        signal_reg <= 8'hff;
        @(posedge clk_sys);
        set_pulse <= 1'b0;
    endtask
    // ****************************************************************
    // punch: one pickup pulse per punch cycle
    // ****************************************************************
    task automatic pickup_cycle();
        @(posedge clk_sys);
        pickup <= 1'b1;
        repeat (3) @(posedge clk_sys);
        pickup <= 1'b0;
        @(posedge clk_sys);
    endtask
endmodule
`default_nettype wire

// ### test/tptc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) \
    begin \
        samples_checked++; \
        if ((got) !== (ex)) begin \
            errors++; \
            $display("unexpected %s expected %0h seen %0h", nm, ex, got); \
        end \
    end
module tptc_top_tb;
    // ****************************************************************
    // setup
    // ****************************************************************
    localparam int POR = 50;
    localparam int MAG = 40;
    localparam int VDS = 10;
    localparam int VDL = 30;
    localparam int XF = 5;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic wb_cyc_i, wb_stb_i, wb_we_i, line_in, punched_ready;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic wb_ack_o, dist_serial, dist_reset, feed_magnet, punched_valid;
    logic shift_pulse, set_pulse, pickup, feed_prev, pk_prev;
    logic [7:0] signal_reg, code_magnet, punched_code, cap_code;
    int errors = 0;
    int samples_checked = 0;
    int feed_rises = 0;
    int cyc_cnt = 0;
    int pk_at = 0;
    int rise_at = 0;
    int cur_len = 0;
    int last_len = 0;
    int por_pulses = 0;
    int n, r0;
    always #2 clk_sys = ~clk_sys;
    tptc_top #(.POR_CYC(POR), .MAG_CYC(MAG), .VD_SHORT_CYC(VDS),
        .VD_LONG_CYC(VDL), .XFER_CYC(XF)) dut_u (.clk_sys(clk_sys),
        .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .line_in(line_in), .dist_serial(dist_serial),
        .dist_reset(dist_reset), .shift_pulse(shift_pulse),
        .signal_reg(signal_reg), .set_pulse(set_pulse), .pickup(pickup),
        .code_magnet(code_magnet), .feed_magnet(feed_magnet),
        .punched_valid(punched_valid), .punched_ready(punched_ready),
        .punched_code(punched_code));
    // set gap keeps its default, equal to the scaled transfer delay
    tptc_far_model far_u (.clk_sys(clk_sys),
        .shift_pulse(shift_pulse), .signal_reg(signal_reg),
        .set_pulse(set_pulse), .pickup(pickup));
    // ****************************************************************
    // monitor of magnets, pickup and distributor reset
    // ****************************************************************
    always @(posedge clk_sys) begin
        cyc_cnt <= cyc_cnt + 1;
        feed_prev <= feed_magnet;
        pk_prev <= pickup;
        if (pickup === 1'b1 && pk_prev !== 1'b1) begin
            pk_at <= cyc_cnt;
        end
        if (feed_magnet === 1'b1 && feed_prev !== 1'b1) begin
            feed_rises <= feed_rises + 1;
            rise_at <= cyc_cnt;
            cap_code <= code_magnet;
        end
        if (feed_magnet === 1'b1) begin
            cur_len <= cur_len + 1;
        end else if (cur_len != 0) begin
            last_len <= cur_len;
            cur_len <= 0;
        end
        if (dist_reset === 1'b1) begin
            por_pulses <= por_pulses + 1;
        end
    end
    // ****************************************************************
    // tasks
    // ****************************************************************
    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic wb_io(input logic we, input logic [7:0] adr,
        input logic [31:0] wd, input logic [3:0] sel);
        int i;
        @(posedge clk_sys);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= wd;
        wb_sel_i <= sel;
        for (i = 0; i < 20; i++) begin
            @(posedge clk_sys);
            if (wb_ack_o === 1'b1) break;
        end
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        if (i == 20) begin
            errors++;
            finish_test();
        end
    endtask
    task automatic punch(input logic fire, input logic [7:0] code);
        int i;
        r0 = feed_rises;
        far_u.pickup_cycle();
        for (i = 0; i < VDL + XF + 20 && feed_rises == r0; i++) begin
            @(posedge clk_sys);
        end
        `CHK("fired", fire, feed_rises != r0)
        if (fire) begin
            `CHK("code_magnet", code, cap_code)
            `CHK("latency", 1'b1, rise_at - pk_at >= VDS + XF &&
                rise_at - pk_at <= VDS + XF + 6)
            repeat (MAG + 8) @(posedge clk_sys);
            `CHK("magnet_len", 1'b1,
                last_len >= MAG && last_len <= MAG + 2)
        end
    endtask
    task automatic pop(input logic [7:0] code);
        `CHK("punched_valid", 1'b1, punched_valid)
        `CHK("punched_code", code, punched_code)
        punched_ready <= 1'b1;
        @(posedge clk_sys);
        punched_ready <= 1'b0;
        @(posedge clk_sys);
    endtask
    // ****************************************************************
    // sequence
    // ****************************************************************
    initial begin
        {wb_cyc_i, wb_stb_i, wb_we_i, line_in, punched_ready} = 5'h00;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'hf;
        wb_dat_i = 32'h0;
        repeat (5) @(posedge clk_sys);
        `CHK("reset_outputs", 10'h000,
            {dist_reset, feed_magnet, code_magnet})
        repeat (5) @(posedge clk_sys);
        nrst <= 1'b1;
        for (n = 0; n < POR + 20 && dist_reset !== 1'b1; n++) begin
            @(posedge clk_sys);
        end
        `CHK("por_delay", 1'b1, n >= POR + 2 && n <= POR + 4)
        $display("test power_on done");
        wb_io(1'b0, tptc_pkg::ADR_CTRL, 32'h0, 4'hf);
        `CHK("ctrl_reset", tptc_pkg::CTRL_RESET, rd)
        wb_io(1'b0, 8'h40, 32'h0, 4'hf);
        `CHK("unmapped", 32'h0, rd)
        wb_io(1'b1, tptc_pkg::ADR_STAT, 32'hffffffff, 4'hf);
        wb_io(1'b0, tptc_pkg::ADR_STAT, 32'h0, 4'hf);
        `CHK("stat_idle", 14'h1000, rd[13:0])
        $display("test registers done");
        for (n = 0; n < 8; n++) begin
            @(posedge clk_sys);
            line_in <= n[0] ^ n[2];
            repeat (2) @(posedge clk_sys);
            `CHK("dist_serial", n[0] ^ n[2], dist_serial)
        end
        $display("test line done");
        far_u.load_char(8'h5a);
        far_u.load_char(8'ha5);
        wb_io(1'b0, tptc_pkg::ADR_STAT, 32'h0, 4'hf);
        `CHK("storage", 8'ha5, rd[7:0])
        `CHK("prime_set", 1'b1, rd[tptc_pkg::STAT_PRIME])
        punch(1'b1, 8'ha5);
        wb_io(1'b0, tptc_pkg::ADR_STAT, 32'h0, 4'hf);
        `CHK("prime_clear", 1'b0, rd[tptc_pkg::STAT_PRIME])
        r0 = feed_rises;
        far_u.pickup_cycle();
        repeat (15) @(posedge clk_sys);
        wb_io(1'b0, tptc_pkg::ADR_STAT, 32'h0, 4'hf);
        `CHK("long_delay", 1'b1, rd[tptc_pkg::STAT_VD_BUSY])
        repeat (20) @(posedge clk_sys);
        wb_io(1'b0, tptc_pkg::ADR_STAT, 32'h0, 4'hf);
        `CHK("delay_idle", 1'b0, rd[tptc_pkg::STAT_VD_BUSY])
        `CHK("kept", 8'ha5, rd[7:0])
        `CHK("no_punch", r0, feed_rises)
        $display("test transfer done");
        far_u.load_char(8'h00);
        punch(1'b1, 8'h00);
        far_u.load_char(8'h3c);
        punch(1'b0, 8'h3c);
        wb_io(1'b0, tptc_pkg::ADR_STAT, 32'h0, 4'hf);
        `CHK("buf_full", 1'b1, rd[tptc_pkg::STAT_BUF_FULL])
        `CHK("full_kept", 8'h3c, rd[7:0])
        pop(8'ha5);
        pop(8'h00);
        `CHK("drained", 1'b0, punched_valid)
        $display("test buffer done");
        wb_io(1'b1, tptc_pkg::ADR_CTRL, 32'h1, 4'hf);
        far_u.load_char(8'h66);
        punch(1'b0, 8'h66);
        wb_io(1'b1, tptc_pkg::ADR_CTRL, 32'h0, 4'h0);
        wb_io(1'b0, tptc_pkg::ADR_CTRL, 32'h0, 4'hf);
        `CHK("ctrl_sel", 32'h1, rd)
        wb_io(1'b1, tptc_pkg::ADR_CTRL, 32'h0, 4'hf);
        far_u.load_char(8'h66);
        punch(1'b1, 8'h66);
        pop(8'h66);
        `CHK("por_once", 1, por_pulses)
        $display("test inhibit done");
        finish_test();
    end
endmodule
`default_nettype wire
